//--- sswd_map.svh
// constants of the subtract / swap / direction-load execution datapath
`ifndef SSWD_MAP_SVH
`define SSWD_MAP_SVH
// opcode patterns on instruction bits 11:6 (low six bits hold d and f)
`define SUB_OPC 6'h02
`define SWAP_OPC 6'h0E
// direction-load is the full word with f in bits 2:0
`define DIRL_HI 9'h000
`define DIRL_REG 3'h6
// field positions
`define OPC_MSB 11
`define OPC_LSB 6
`define DEST_BIT 5
`define FADDR_MSB 4
`define DIRL_HI_MSB 11
`define DIRL_HI_LSB 3
`define DIRL_REG_MSB 2
// nibble positions inside a data word
`define NIB_LO_MSB 3
`define NIB_HI_LSB 4
`define NIB_HI_MSB 7
`define NIB_CARRY 4
// reset values
`define ACC_RST 8'h00
`define DIR_RST 8'hFF
`endif

//--- sswd_pkg.sv
// types of the subtract / swap / direction-load execution datapath
`default_nettype none
package sswd_pkg;
   // decoded operation
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_SUB = 2'b01,
      OP_SWAP = 2'b10,
      OP_DIRL = 2'b11
   } op_kind_t;
endpackage : sswd_pkg
`default_nettype wire

//--- subtract_swap_direction_exec.sv
// execution datapath for subtract, nibble swap and direction load
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "sswd_map.svh"
module subtract_swap_direction_exec
   import sswd_pkg::*;
#(
   parameter int DATA_W = 8, // datapath width
   parameter int ADDR_W = 5 // file address width
) (
   input wire logic clk_in, // instruction clock, 250 MHz
   input wire logic resetn_in, // asynchronous reset, active low
   input wire logic exec_in, // one-cycle strobe: instr_in is valid
   input wire logic [11:0] instr_in, // instruction word
   input wire logic [DATA_W-1:0] file_rd_data_in, // addressed file register, same cycle
   output logic [ADDR_W-1:0] file_addr_out, // file address, combinational
   output logic file_wr_out, // file write strobe, combinational handshake
   output logic [DATA_W-1:0] file_wr_data_out, // file write data
   input wire logic acc_wr_in, // outside load of the accumulator
   input wire logic [DATA_W-1:0] acc_wr_data_in, // data for that load
   output logic [DATA_W-1:0] acc_out, // accumulator
   output logic [DATA_W-1:0] direction_out, // port direction register
   output logic carry_out, // carry, 1 means no borrow
   output logic digit_borrow_flag_out, // digit carry from low nibble
   output logic zero_out // result was zero
);
   // the nibble logic and the opcode table assume exactly these widths
   if (DATA_W != 8 || ADDR_W != 5) begin : g_bad_width
      $error("datapath serves only 8-bit data and 5-bit file addresses");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   op_kind_t op; // operation of this cycle
   logic dest_file; // destination bit
   logic [DATA_W:0] diff_full; // difference with carry out
   logic [4:0] diff_low; // low nibble difference with carry out
   logic [DATA_W-1:0] result; // value bound for destination

   // decode kept in a function so the opcode table reads in one place
   function automatic op_kind_t decode_op(input logic [11:0] w);
      if (w[`OPC_MSB:`OPC_LSB] == `SUB_OPC) decode_op = OP_SUB;
      else if (w[`OPC_MSB:`OPC_LSB] == `SWAP_OPC) decode_op = OP_SWAP;
      else if (w[`DIRL_HI_MSB:`DIRL_HI_LSB] == `DIRL_HI && w[`DIRL_REG_MSB:0] == `DIRL_REG)
         decode_op = OP_DIRL;
      else decode_op = OP_NONE;
   endfunction : decode_op

   // combinational execute: all in one cycle, writes land at the next edge
   always_comb begin
      op = exec_in ? decode_op(instr_in) : OP_NONE;
      dest_file = instr_in[`DEST_BIT];
      // two's complement: f + ~w + 1, carry set means no borrow
      diff_full = {1'b0, file_rd_data_in} + {1'b0, ~acc_out} + 9'h001;
      // the nibble carry is worked apart so the digit flag needs no adder tap
      diff_low = {1'b0, file_rd_data_in[`NIB_LO_MSB:0]}
         + {1'b0, ~acc_out[`NIB_LO_MSB:0]} + 5'h01;
      unique case (op)
         OP_SUB: result = diff_full[DATA_W-1:0];
         OP_SWAP: result = {file_rd_data_in[`NIB_LO_MSB:0],
            file_rd_data_in[`NIB_HI_MSB:`NIB_HI_LSB]};
         OP_DIRL: result = acc_out; // no file or accumulator destination
         OP_NONE: result = acc_out; // idle: nothing is written
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // file port: address always from the instruction, write only to file destination
   assign file_addr_out = instr_in[`FADDR_MSB:0];
   assign file_wr_out = (op == OP_SUB || op == OP_SWAP) && dest_file;
   assign file_wr_data_out = result;

   ////////////////////////////////////////////////////////////////////////////////
   // accumulator; an instruction result wins over the outside load
   // a losing outside load is dropped, not deferred; the caller must repeat it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_out <= `ACC_RST;
      end else if ((op == OP_SUB || op == OP_SWAP) && !dest_file) begin
         acc_out <= result;
      end else if (acc_wr_in) begin
         acc_out <= acc_wr_data_in;
      end
   end

   // direction register, all inputs after reset
   // refused fields decode to no operation and never reach this register
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         direction_out <= `DIR_RST;
      end else if (op == OP_DIRL) begin
         direction_out <= acc_out;
      end
   end

   // flags move on subtract only; swap and direction load leave them
   // they hold on idle cycles, so a later swap sees the last subtract's flags
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         carry_out <= 1'b0;
         digit_borrow_flag_out <= 1'b0;
         zero_out <= 1'b0;
      end else if (op == OP_SUB) begin
         carry_out <= diff_full[DATA_W];
         digit_borrow_flag_out <= diff_low[`NIB_CARRY];
         zero_out <= (diff_full[DATA_W-1:0] == '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   // difference into the accumulator, wrapped to the data width
   property p_sub_value;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SUB && !dest_file) |=> acc_out == $past(file_rd_data_in) - $past(acc_out);
   endproperty
   a_sub_value: assert property (p_sub_value) else $error("subtract result wrong");
   // carry set means the file value was not below the accumulator
   property p_sub_carry;
      @(posedge clk_in) disable iff (!resetn_in)
      op == OP_SUB |=> carry_out == ($past(file_rd_data_in) >= $past(acc_out));
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("carry wrong");
   // zero flag follows equal operands
   property p_sub_zero;
      @(posedge clk_in) disable iff (!resetn_in)
      op == OP_SUB |=> zero_out == ($past(file_rd_data_in) == $past(acc_out));
   endproperty
   a_sub_zero: assert property (p_sub_zero) else $error("zero flag wrong");
   // digit flag is the carry out of the low nibble, 1 means no nibble borrow
   property p_sub_digit;
      @(posedge clk_in) disable iff (!resetn_in)
      op == OP_SUB |=>
         digit_borrow_flag_out == ($past(file_rd_data_in[3:0]) >= $past(acc_out[3:0]));
   endproperty
   a_sub_digit: assert property (p_sub_digit) else $error("digit flag wrong");
   // difference back into the file, accumulator left alone
   property p_sub_file;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SUB && dest_file) |-> file_wr_out && file_wr_data_out == file_rd_data_in - acc_out
         ##1 acc_out == $past(acc_out) || $past(acc_wr_in);
   endproperty
   a_sub_file: assert property (p_sub_file) else $error("subtract to file wrong");
   // subtract into the accumulator must not touch the file
   property p_sub_keep_file;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SUB && !dest_file) |-> !file_wr_out;
   endproperty
   a_sub_keep_file: assert property (p_sub_keep_file) else $error("file written");
   // swapped value lands in the accumulator
   property p_swap_value;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SWAP && !dest_file) |=>
         acc_out == {$past(file_rd_data_in[3:0]), $past(file_rd_data_in[7:4])};
   endproperty
   a_swap_value: assert property (p_swap_value) else $error("swap result wrong");
   // swapped value on the file port when the file is the destination
   property p_swap_data;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SWAP && dest_file) |->
         file_wr_data_out == {file_rd_data_in[3:0], file_rd_data_in[7:4]};
   endproperty
   a_swap_data: assert property (p_swap_data) else $error("swap file data wrong");
   // only a subtract moves the flags
   property p_swap_flags;
      @(posedge clk_in) disable iff (!resetn_in)
      op != OP_SUB |=> $stable({carry_out, digit_borrow_flag_out, zero_out});
   endproperty
   a_swap_flags: assert property (p_swap_flags) else $error("flags moved");
   // file strobe follows the destination bit on a swap
   property p_swap_file;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SWAP) |-> file_wr_out == dest_file;
   endproperty
   a_swap_file: assert property (p_swap_file) else $error("swap routing wrong");
   // swap back into the file leaves the accumulator, unless loaded from outside
   property p_swap_keep_acc;
      @(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SWAP && dest_file && !acc_wr_in) |=> $stable(acc_out);
   endproperty
   a_swap_keep_acc: assert property (p_swap_keep_acc) else $error("acc moved");
   // direction register takes the accumulator of the executing cycle
   property p_dirl;
      @(posedge clk_in) disable iff (!resetn_in)
      op == OP_DIRL |=> direction_out == $past(acc_out);
   endproperty
   a_dirl: assert property (p_dirl) else $error("direction load wrong");
   // direction load never writes the file register
   property p_dirl_no_write;
      @(posedge clk_in) disable iff (!resetn_in)
      op == OP_DIRL |-> !file_wr_out;
   endproperty
   a_dirl_no_write: assert property (p_dirl_no_write) else $error("file written");
   // direction load on any field but the port one is refused
   property p_dirl_refused;
      @(posedge clk_in) disable iff (!resetn_in)
      (exec_in && instr_in[11:3] == '0 && instr_in[2:0] != 3'h6) |=> $stable(direction_out);
   endproperty
   a_dirl_refused: assert property (p_dirl_refused) else $error("bad field loaded");
   // only a strobed instruction with a file destination raises the write strobe
   property p_wr_needs_exec;
      @(posedge clk_in) disable iff (!resetn_in)
      file_wr_out |-> exec_in && dest_file;
   endproperty
   a_wr_needs_exec: assert property (p_wr_needs_exec) else $error("stray file write");
   // with no operation and no outside load the registers stand
   property p_one_cycle;
      @(posedge clk_in) disable iff (!resetn_in)
      op == OP_NONE && !acc_wr_in |=> $stable(acc_out) && $stable(direction_out);
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("state moved without op");
   // main scenarios: zero result, borrow, swap to file, direction load, back to back
   c_sub_zero: cover property (@(posedge clk_in) disable iff (!resetn_in)
      op == OP_SUB ##1 zero_out);
   c_sub_borrow: cover property (@(posedge clk_in) disable iff (!resetn_in)
      op == OP_SUB ##1 !carry_out);
   c_swap_file: cover property (@(posedge clk_in) disable iff (!resetn_in)
      op == OP_SWAP && dest_file);
   c_dirl: cover property (@(posedge clk_in) disable iff (!resetn_in) op == OP_DIRL);
   c_b2b: cover property (@(posedge clk_in) disable iff (!resetn_in)
      (op == OP_SWAP && !dest_file) ##1 op == OP_SUB);
endmodule : subtract_swap_direction_exec
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the subtract / swap / direction-load datapath
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic exec_in = 1'b0;
   logic [11:0] instr_in = 12'h000;
   logic acc_wr_in = 1'b0;
   logic [7:0] acc_wr_data_in = 8'h00;
   logic [7:0] file_rd_data_in;
   logic [4:0] file_addr_out;
   logic file_wr_out;
   logic [7:0] file_wr_data_out, acc_out, direction_out;
   logic carry_out, digit_borrow_flag_out, zero_out;
   logic [7:0] fmem [32]; // file register model
   logic [2:0] flg; // flags before an operation that must keep them
   int failures = 0;
   int n_compared = 0;
   // operand pairs: file value, accumulator value
   logic [15:0] sub_tab [4] = '{16'h0302, 16'h0202, 16'h0102, 16'h1001};
   subtract_swap_direction_exec dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .exec_in(exec_in), .instr_in(instr_in), .file_rd_data_in(file_rd_data_in),
      .file_addr_out(file_addr_out), .file_wr_out(file_wr_out),
      .file_wr_data_out(file_wr_data_out), .acc_wr_in(acc_wr_in),
      .acc_wr_data_in(acc_wr_data_in), .acc_out(acc_out), .direction_out(direction_out),
      .carry_out(carry_out), .digit_borrow_flag_out(digit_borrow_flag_out),
      .zero_out(zero_out));
   initial forever #2 clk_in = ~clk_in;
   // file read is combinational, the write lands at the strobed edge
   assign file_rd_data_in = fmem[file_addr_out];
   always @(posedge clk_in) if (file_wr_out) fmem[file_addr_out] <= file_wr_data_out;
   ////////////////////////////////////////////////////////////////
   // one instruction, then settle past the edge that executed it
   task automatic run(input logic [11:0] ins);
      @(posedge clk_in);
      exec_in <= 1'b1;
      instr_in <= ins;
      @(posedge clk_in);
      exec_in <= 1'b0;
      #1;
      flg = {carry_out, digit_borrow_flag_out, zero_out};
   endtask : run
   task automatic load_acc(input logic [7:0] v);
      @(posedge clk_in);
      acc_wr_in <= 1'b1;
      acc_wr_data_in <= v;
      @(posedge clk_in);
      acc_wr_in <= 1'b0;
   endtask : load_acc
   // subtract with both destinations, borrow and zero cases
   task automatic test_sub;
      logic [7:0] f, w;
      for (int i = 0; i < 4; i++) begin
         f = sub_tab[i][15:8];
         w = sub_tab[i][7:0];
         fmem[3] = f;
         load_acc(w);
         run({6'h02, i[0], 5'h03});
         `CHK("sub acc", (i[0] ? w : f - w), acc_out)
         `CHK("sub file", (i[0] ? f - w : f), fmem[3])
         `CHK("carry", (f >= w), carry_out)
         `CHK("digit", (f[3:0] >= w[3:0]), digit_borrow_flag_out)
         `CHK("zero", (f == w), zero_out)
      end
   endtask : test_sub
   // swap to each destination at a high file address; flags must hold
   task automatic test_swap;
      logic [2:0] keep;
      keep = flg;
      fmem[25] = 8'hA5;
      run(12'h399);
      `CHK("swap acc", 8'h5A, acc_out)
      `CHK("swap file kept", 8'hA5, fmem[25])
      run(12'h3B9);
      `CHK("swap file", 8'h5A, fmem[25])
      `CHK("swap acc kept", 8'h5A, acc_out)
      `CHK("swap flags", keep, flg)
   endtask : test_swap
   // direction load on field 6, refused on field 5
   task automatic test_dir;
      logic [2:0] keep;
      keep = flg;
      load_acc(8'hA5);
      run(12'h006);
      `CHK("dir load", 8'hA5, direction_out)
      `CHK("dir flags", keep, flg)
      load_acc(8'h3C);
      run(12'h005);
      `CHK("dir refused", 8'hA5, direction_out)
   endtask : test_dir
   // swap into the accumulator beats an outside load, then feeds a subtract
   task automatic test_b2b;
      fmem[1] = 8'h30;
      fmem[2] = 8'h10;
      @(posedge clk_in);
      exec_in <= 1'b1;
      instr_in <= 12'h381;
      acc_wr_in <= 1'b1;
      acc_wr_data_in <= 8'hEE;
      @(posedge clk_in);
      instr_in <= 12'h0A2;
      acc_wr_in <= 1'b0;
      run(12'h000);
      `CHK("b2b acc", 8'h03, acc_out)
      `CHK("b2b file", 8'h0D, fmem[2])
      `CHK("b2b digit", 1'b0, digit_borrow_flag_out)
   endtask : test_b2b
   task automatic final_report;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      foreach (fmem[i]) fmem[i] = 8'h00;
      repeat (10) @(posedge clk_in);
      resetn_in <= 1'b1;
      test_sub();
      test_swap();
      test_dir();
      test_b2b();
      final_report();
   end
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      failures++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
